// ### rtl/scan_pkg.sv
// Constants shared by the test access port data registers, their checks and the bench.
package scan_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Instruction register.
	localparam int        IR_W       = 5;
	localparam logic [4:0] OP_IDCODE = 5'h00;
	localparam logic [4:0] OP_SAMPLE = 5'h01;
	localparam logic [4:0] OP_EXTEST = 5'h02;
	localparam logic [4:0] OP_USER   = 5'h04;
	localparam logic [4:0] OP_LDADDR = 5'h08;
	localparam logic [4:0] OP_MEMRD  = 5'h09;
	localparam logic [4:0] OP_MEMWR  = 5'h0a;
	localparam logic [4:0] OP_SOFT_RESTART = 5'h0c;
	localparam logic [4:0] OP_SAVE   = 5'h0d;
	localparam logic [4:0] OP_BYPASS = 5'h1f;
	localparam logic [4:0] IR_CAPTURE = 5'h01;

	////////////////////////////////////////////////////////////////////////////
	// Data register widths and identification fields.
	localparam int ID_W      = 32;
	localparam int MEM_W     = 8;
	localparam int SLAVE_W   = 7;
	localparam int FW_W      = 8;
	localparam int BSR_W     = 198;
	localparam int N_OUT     = 9;
	localparam int N_IN      = 4;

	////////////////////////////////////////////////////////////////////////////
	// Boundary cell positions.
	localparam int CELL_OUT0    = 148;
	localparam int CELL_GPIO2I  = 183;
	localparam int CELL_GPIO1I  = 184;
	localparam int CELL_SDAI    = 185;
	localparam int CELL_ADDR0_B = 186;
	localparam int CELL_ADDR0_A = 187;
	localparam int CELL_ADDR1_B = 188;
	localparam int CELL_ADDR1_A = 189;
	localparam int CELL_SCL     = 190;

	////////////////////////////////////////////////////////////////////////////
	// Address select pin state codes, written {a, b}.
	localparam logic [1:0] ADDR_HIZ  = 2'h0;
	localparam logic [1:0] ADDR_LOW  = 2'h1;
	localparam logic [1:0] ADDR_HIGH = 2'h2;

	////////////////////////////////////////////////////////////////////////////
	// Timing of the sampled test clock.
	localparam int CLK_NS   = 100;
	localparam int TCK_NS   = 800;
	localparam int TCK_CYC  = TCK_NS / CLK_NS;

	////////////////////////////////////////////////////////////////////////////
	// Controller states, one-hot.
	typedef enum logic [15:0] {
		S_RESET    = 16'h0001,
		S_IDLE     = 16'h0002,
		S_SEL_DR   = 16'h0004,
		S_CAP_DR   = 16'h0008,
		S_SHIFT_DR = 16'h0010,
		S_EX1_DR   = 16'h0020,
		S_PAUSE_DR = 16'h0040,
		S_EX2_DR   = 16'h0080,
		S_UPD_DR   = 16'h0100,
		S_SEL_IR   = 16'h0200,
		S_CAP_IR   = 16'h0400,
		S_SHIFT_IR = 16'h0800,
		S_EX1_IR   = 16'h1000,
		S_PAUSE_IR = 16'h2000,
		S_EX2_IR   = 16'h4000,
		S_UPD_IR   = 16'h8000
	} tap_e;

endpackage : scan_pkg

// ### rtl/wr_buffer.sv
// Two-entry buffer that holds committed memory writes until the receiver takes them.
`timescale 1ns/1ps
module wr_buffer #(
	parameter int WIDTH = 16
) (
	// Clock and reset.
	input  wire logic             clk,
	input  wire logic             rst_n,
	// Filling side.
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Draining side.
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);

	logic             v0_q, v0_d, v1_q, v1_d;
	logic [WIDTH-1:0] head_q, head_d, tail_q, tail_d;
	logic             push, pop;

	////////////////////////////////////////////////////////////////////////////
	// The head entry drives the outputs directly so they come straight from flops.
	always_comb begin
		push   = in_valid && !v1_q;
		pop    = v0_q && out_ready;
		v0_d   = v0_q;
		v1_d   = v1_q;
		head_d = head_q;
		tail_d = tail_q;
		if (pop) begin
			head_d = v1_q ? tail_q : in_data;
			v1_d   = 1'b0;
			v0_d   = v1_q || push;
		end else if (push) begin
			if (v0_q) begin
				tail_d = in_data;
				v1_d   = 1'b1;
			end else begin
				head_d = in_data;
				v0_d   = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			v0_q   <= 1'b0;
			v1_q   <= 1'b0;
			head_q <= '0;
			tail_q <= '0;
		end else begin
			v0_q   <= v0_d;
			v1_q   <= v1_d;
			head_q <= head_d;
			tail_q <= tail_d;
		end
	end

	// A full buffer refuses more; the source holds its word until this rises.
	assign in_ready  = !v1_q;
	assign out_valid = v0_q;
	assign out_data  = head_q;

endmodule : wr_buffer

// ### rtl/jtag_data_regs.sv
// Test data registers, extension instructions and boundary chain behind the test port.
`timescale 1ns/1ps
module jtag_data_regs #(
	parameter logic [3:0]  VERSION = 4'h1,   // Arbitrary value.
	parameter logic [15:0] PART_ID = 16'h0a5c, // Arbitrary value.
	parameter logic [10:0] MAKER   = 11'h2b3   // Arbitrary value.
) (
	// Clock and reset.
	input  wire logic                         clk,
	input  wire logic                         rst_n,
	// Test port pins, asynchronous to clk.
	input  wire logic                         tck,
	input  wire logic                         tms,
	input  wire logic                         tdi,
	output logic                              tdo,
	output logic                              tdo_oe,
	// Functional pin values from the device core, cell order 148 upward.
	input  wire logic [scan_pkg::N_OUT-1:0]   func_out,
	// Pin drive after the boundary override.
	output logic [scan_pkg::N_OUT-1:0]        pin_out,
	// Digital input pins {scl, sda, gpio1, gpio2}, asynchronous.
	input  wire logic [scan_pkg::N_IN-1:0]    pin_in,
	// Decoded address select pin states {a, b} from the core.
	input  wire logic [1:0]                   slave_addr_pin_0,
	input  wire logic [1:0]                   slave_addr_pin_1,
	// Identity sources for the user code.
	input  wire logic [scan_pkg::SLAVE_W-1:0] slave_addr,
	input  wire logic [scan_pkg::FW_W-1:0]    fw_version,
	// Memory access.
	output logic [scan_pkg::MEM_W-1:0]        mem_addr,
	input  wire logic [scan_pkg::MEM_W-1:0]   mem_rdata,
	output logic                              mem_wr_valid,
	input  wire logic                         mem_wr_ready,
	output logic [scan_pkg::MEM_W-1:0]        mem_wr_addr,
	output logic [scan_pkg::MEM_W-1:0]        mem_wr_data,
	// Device actions.
	output logic                              soft_restart_instr,
	output logic                              save_pulse
);
	import scan_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Boundary capture image: reserved cells stay zero.
	// Output cells sit from 148 upward and input cells from 183 upward.
	function automatic logic [BSR_W-1:0] bsr_image(input logic [N_OUT-1:0] outs,
			input logic [N_IN-1:0] ins, input logic [1:0] a0, input logic [1:0] a1);
		logic [BSR_W-1:0] v;
		v = '0;
		v[CELL_OUT0 +: N_OUT] = outs;
		v[CELL_GPIO2I] = ins[0];
		v[CELL_GPIO1I] = ins[1];
		v[CELL_SDAI]   = ins[2];
		v[CELL_ADDR0_B] = a0[0];
		v[CELL_ADDR0_A] = a0[1];
		v[CELL_ADDR1_B] = a1[0];
		v[CELL_ADDR1_A] = a1[1];
		v[CELL_SCL]    = ins[3];
		return v;
	endfunction : bsr_image

	// Controller step on a rising test clock.
	// A corrupted state code falls back to test-logic-reset rather than wandering.
	function automatic tap_e tap_next(input tap_e s, input logic m);
		unique case (s)
			S_RESET:    tap_next = m ? S_RESET  : S_IDLE;
			S_IDLE:     tap_next = m ? S_SEL_DR : S_IDLE;
			S_SEL_DR:   tap_next = m ? S_SEL_IR : S_CAP_DR;
			S_CAP_DR:   tap_next = m ? S_EX1_DR : S_SHIFT_DR;
			S_SHIFT_DR: tap_next = m ? S_EX1_DR : S_SHIFT_DR;
			S_EX1_DR:   tap_next = m ? S_UPD_DR : S_PAUSE_DR;
			S_PAUSE_DR: tap_next = m ? S_EX2_DR : S_PAUSE_DR;
			S_EX2_DR:   tap_next = m ? S_UPD_DR : S_SHIFT_DR;
			S_UPD_DR:   tap_next = m ? S_SEL_DR : S_IDLE;
			S_SEL_IR:   tap_next = m ? S_RESET  : S_CAP_IR;
			S_CAP_IR:   tap_next = m ? S_EX1_IR : S_SHIFT_IR;
			S_SHIFT_IR: tap_next = m ? S_EX1_IR : S_SHIFT_IR;
			S_EX1_IR:   tap_next = m ? S_UPD_IR : S_PAUSE_IR;
			S_PAUSE_IR: tap_next = m ? S_EX2_IR : S_PAUSE_IR;
			S_EX2_IR:   tap_next = m ? S_UPD_IR : S_SHIFT_IR;
			S_UPD_IR:   tap_next = m ? S_SEL_DR : S_IDLE;
			default:    tap_next = S_RESET;
		endcase
	endfunction : tap_next

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: three stages, a level counts once stages two and three agree.
	// The price is three to four clocks of latency, so each test clock phase needs four clocks.
	localparam int NS = 3 + N_IN;
	logic [NS-1:0] s1_q, s2_q, s3_q, lvl_q, lvl_d;
	logic          tck_rise, tck_fall, tms_s, tdi_s;

	always_comb begin
		for (int i = 0; i < NS; i++) begin
			lvl_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : lvl_q[i];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q  <= '0;
			s2_q  <= '0;
			s3_q  <= '0;
			lvl_q <= '0;
		end else begin
			s1_q  <= {pin_in, tdi, tms, tck};
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			lvl_q <= lvl_d;
		end
	end

	// Edges are found on the agreed level, so one glitchy sample cannot double-clock.
	assign tck_rise = (lvl_d[0] != lvl_q[0]) && lvl_d[0];
	assign tck_fall = (lvl_d[0] != lvl_q[0]) && !lvl_d[0];
	assign tms_s    = lvl_q[1];
	assign tdi_s    = lvl_q[2];

	////////////////////////////////////////////////////////////////////////////
	// Scan state: controller, instruction and data registers.
	// One 32-bit word serves identification and user code, as only one is ever selected.
	tap_e              tap_q, tap_d;
	logic [IR_W-1:0]   ir_sr_q, ir_sr_d, ir_q, ir_d;
	logic [ID_W-1:0]   w32_q, w32_d;
	logic              byp_q, byp_d;
	logic [MEM_W-1:0]  addr_sr_q, addr_sr_d, rd_sr_q, rd_sr_d, wr_sr_q, wr_sr_d;
	logic [MEM_W-1:0]  addr_q, addr_d;
	logic [BSR_W-1:0]  bsr_q, bsr_d;
	logic [N_OUT-1:0]  bout_q, bout_d, pin_q, pin_d;
	logic              tdo_q, tdo_d, oe_q, oe_d;
	logic              rst_pulse_q, rst_pulse_d, save_q, save_d;
	// One committed write may wait here while the buffer is full.
	logic              pend_q, pend_d;
	logic [2*MEM_W-1:0] pend_w_q, pend_w_d;
	logic [2*MEM_W-1:0] wr_word;
	logic              buf_ready;
	logic              bsr_sel;

	assign bsr_sel = (ir_q == OP_SAMPLE) || (ir_q == OP_EXTEST);

	// Next-state logic: a rising test clock captures and shifts, a falling one updates.
	// All edge work is done in the single clk cycle in which an edge is accepted; the reset force applies every cycle.
	always_comb begin
		tap_d       = tap_q;
		ir_sr_d     = ir_sr_q;
		ir_d        = ir_q;
		w32_d       = w32_q;
		byp_d       = byp_q;
		addr_sr_d   = addr_sr_q;
		rd_sr_d     = rd_sr_q;
		wr_sr_d     = wr_sr_q;
		addr_d      = addr_q;
		bsr_d       = bsr_q;
		bout_d      = bout_q;
		tdo_d       = tdo_q;
		oe_d        = oe_q;
		rst_pulse_d = 1'b0;
		save_d      = 1'b0;
		pend_d      = pend_q && !buf_ready;
		pend_w_d    = pend_w_q;
		if (tck_rise) begin
			tap_d = tap_next(tap_q, tms_s);
			if (tap_q == S_CAP_IR) begin
				ir_sr_d = IR_CAPTURE;
			end else if (tap_q == S_SHIFT_IR) begin
				ir_sr_d = {tdi_s, ir_sr_q[IR_W-1:1]};
			end else if (tap_q == S_CAP_DR) begin
				byp_d = 1'b0;
				if (ir_q == OP_IDCODE) begin
					w32_d = {VERSION, PART_ID, MAKER, 1'b1};
				end else if (ir_q == OP_USER) begin
					w32_d = {{(ID_W-SLAVE_W-FW_W){1'b0}}, slave_addr, fw_version};
				end else if (ir_q == OP_MEMRD) begin
					// The byte at the loaded address is taken as it stands now.
					rd_sr_d = mem_rdata;
				end else if (bsr_sel) begin
					// Output cells see the pin value actually driven.
					bsr_d = bsr_image(pin_q, lvl_q[NS-1:3], slave_addr_pin_0,
						slave_addr_pin_1);
				end
			end else if (tap_q == S_SHIFT_DR) begin
				unique case (ir_q)
					OP_IDCODE, OP_USER: w32_d = {tdi_s, w32_q[ID_W-1:1]};
					OP_LDADDR: addr_sr_d = {tdi_s, addr_sr_q[MEM_W-1:1]};
					OP_MEMRD:  rd_sr_d = {tdi_s, rd_sr_q[MEM_W-1:1]};
					OP_MEMWR:  wr_sr_d = {tdi_s, wr_sr_q[MEM_W-1:1]};
					OP_SAMPLE, OP_EXTEST: bsr_d = {tdi_s, bsr_q[BSR_W-1:1]};
					default:   byp_d = tdi_s;
				endcase
			end
		end
		if (tck_fall) begin
			// Output changes on the falling test clock, as the controller expects.
			oe_d = (tap_q == S_SHIFT_IR) || (tap_q == S_SHIFT_DR);
			if (tap_q == S_SHIFT_IR) begin
				tdo_d = ir_sr_q[0];
			end else if (tap_q == S_SHIFT_DR) begin
				unique case (ir_q)
					OP_IDCODE, OP_USER: tdo_d = w32_q[0];
					OP_LDADDR: tdo_d = addr_sr_q[0];
					OP_MEMRD:  tdo_d = rd_sr_q[0];
					OP_MEMWR:  tdo_d = wr_sr_q[0];
					OP_SAMPLE, OP_EXTEST: tdo_d = bsr_q[0];
					default:   tdo_d = byp_q;
				endcase
			end
			// Parallel outputs change only here or on test-logic-reset, never while a register shifts.
			if (tap_q == S_UPD_IR) begin
				ir_d        = ir_sr_q;
				rst_pulse_d = (ir_sr_q == OP_SOFT_RESTART);
				save_d      = (ir_sr_q == OP_SAVE);
			end else if (tap_q == S_UPD_DR) begin
				if (ir_q == OP_LDADDR) begin
					addr_d = addr_sr_q;
				end else if (ir_q == OP_MEMWR) begin
					pend_d   = 1'b1;
					pend_w_d = {addr_q, wr_sr_q};
				end else if (bsr_sel) begin
					bout_d = bsr_q[CELL_OUT0 +: N_OUT];
				end
			end
		end
		// Test-logic-reset forces identification whatever the test clock does.
		if (tap_q == S_RESET) begin
			ir_d = OP_IDCODE;
			oe_d = 1'b0;
		end
	end

	// Pins follow the boundary cells under EXTEST and the core otherwise.
	// Leaving EXTEST hands the pins back to the core on the next clock.
	assign pin_d = (ir_q == OP_EXTEST) ? bout_q : func_out;

	// Register the scan state; every decision is made in the process and the pin select above.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tap_q       <= S_RESET;
			ir_sr_q     <= '0;
			ir_q        <= OP_IDCODE;
			w32_q       <= '0;
			byp_q       <= 1'b0;
			addr_sr_q   <= '0;
			rd_sr_q     <= '0;
			wr_sr_q     <= '0;
			addr_q      <= '0;
			bsr_q       <= '0;
			bout_q      <= '0;
			pin_q       <= '0;
			tdo_q       <= 1'b0;
			oe_q        <= 1'b0;
			rst_pulse_q <= 1'b0;
			save_q      <= 1'b0;
			pend_q      <= 1'b0;
			pend_w_q    <= '0;
		end else begin
			tap_q       <= tap_d;
			ir_sr_q     <= ir_sr_d;
			ir_q        <= ir_d;
			w32_q       <= w32_d;
			byp_q       <= byp_d;
			addr_sr_q   <= addr_sr_d;
			rd_sr_q     <= rd_sr_d;
			wr_sr_q     <= wr_sr_d;
			addr_q      <= addr_d;
			bsr_q       <= bsr_d;
			bout_q      <= bout_d;
			pin_q       <= pin_d;
			tdo_q       <= tdo_d;
			oe_q        <= oe_d;
			rst_pulse_q <= rst_pulse_d;
			save_q      <= save_d;
			pend_q      <= pend_d;
			pend_w_q    <= pend_w_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Committed writes wait in the buffer; a stalled receiver loses no word.
	// A fourth write before the pending one enters would overwrite it.
	wr_buffer #(
		.WIDTH     (2*MEM_W)
	) u_wr_buffer (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_valid  (pend_q),
		.in_ready  (buf_ready),
		.in_data   (pend_w_q),
		.out_valid (mem_wr_valid),
		.out_ready (mem_wr_ready),
		.out_data  (wr_word)
	);

	// Every output below is a flop of this block or of the buffer.
	assign mem_wr_addr        = wr_word[2*MEM_W-1:MEM_W];
	assign mem_wr_data        = wr_word[MEM_W-1:0];
	assign tdo                = tdo_q;
	assign tdo_oe             = oe_q;
	assign pin_out            = pin_q;
	assign mem_addr           = addr_q;
	assign soft_restart_instr = rst_pulse_q;
	assign save_pulse         = save_q;

endmodule : jtag_data_regs

// ### bench/jtag_data_regs_asserts.sv
// Concurrent checks on the outputs of the test port data register block.
`timescale 1ns/1ps
module jtag_data_regs_asserts
	import scan_pkg::*;
(
	// Clock and reset.
	input wire logic             clk,
	input wire logic             rst_n,
	// Test port pins watched.
	input wire logic             tck,
	input wire logic             tdo,
	input wire logic             tdo_oe,
	// Memory access and device actions.
	input wire logic [MEM_W-1:0] mem_addr,
	input wire logic             mem_wr_valid,
	input wire logic             mem_wr_ready,
	input wire logic [MEM_W-1:0] mem_wr_addr,
	input wire logic [MEM_W-1:0] mem_wr_data,
	input wire logic             soft_restart_instr,
	input wire logic             save_pulse
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	////////////////////////////////////////////////////////////////////////
	// Action pulses last one cycle and only follow a test clock fall.
	a_restart_pulse: assert property (soft_restart_instr |=> !soft_restart_instr)
		else $error("restart pulse longer than one cycle");
	a_save_pulse: assert property ($rose(save_pulse) |=> $fell(save_pulse))
		else $error("save pulse longer than one cycle");
	a_action_excl: assert property (!(soft_restart_instr && save_pulse))
		else $error("restart and save pulsed together");
	// The pin is seen three to four clocks late, so look at it where the change was launched.
	a_restart_at_fall: assert property ($rose(soft_restart_instr) |->
		!$past(tck) && !$past(tck, 3))
		else $error("restart pulse not after a test clock fall");
	// The serial output only moves after a fall, so the host may sample it at the rise.
	a_tdo_at_fall: assert property ($changed(tdo) |-> !$past(tck) && !$past(tck, 3))
		else $error("tdo changed while test clock high");
	a_oe_at_fall: assert property ($changed(tdo_oe) |-> !$past(tck) && !$past(tck, 3))
		else $error("tdo enable changed while test clock high");
	a_addr_at_update: assert property ($changed(mem_addr) |->
		!$past(tck) && !$past(tck, 3) && !tdo_oe)
		else $error("memory address changed outside update");
	// A stalled word must stand still so the receiver loses nothing.
	a_wr_hold: assert property (mem_wr_valid && !mem_wr_ready |=>
		mem_wr_valid && $stable({mem_wr_addr, mem_wr_data}))
		else $error("write word dropped or changed while stalled");
	a_wr_rise_idle: assert property ($rose(mem_wr_valid) |-> !tdo_oe)
		else $error("write word appeared during a shift");
endmodule : jtag_data_regs_asserts

bind jtag_data_regs jtag_data_regs_asserts chk_u (
	.clk(clk), .rst_n(rst_n), .tck(tck), .tdo(tdo), .tdo_oe(tdo_oe), .mem_addr(mem_addr),
	.mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready), .mem_wr_addr(mem_wr_addr),
	.mem_wr_data(mem_wr_data), .soft_restart_instr(soft_restart_instr), .save_pulse(save_pulse)
);

// ### bench/scan_host.sv
// Boundary scan host model that clocks the test port and collects the serial output.
`timescale 1ns/1ps
module scan_host
	import scan_pkg::*;
(
	// Pacing clock.
	input  wire logic clk,
	// Test port pins.
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	input  wire logic tdo
);
	// The test clock rests low between scans.
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// One test clock: four cycles low, four high; tdo is taken just before the fall,
	// which is still the value present at the rise since it only moves after a fall.
	task automatic tick(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		repeat (TCK_CYC / 2) @(negedge clk);
		tck = 1'b1;
		repeat (TCK_CYC / 2) @(negedge clk);
		q = tdo;
		tck = 1'b0;
	endtask : tick

	// Five high mode ticks reach the reset state, then one low tick parks in idle.
	task automatic reset_tap();
		logic q;
		repeat (5) tick(1'b1, ~tdi, q);
		tick(1'b0, ~tdi, q);
	endtask : reset_tap

	// Instruction or data scan from idle back to idle, least significant bit first.
	task automatic scan(input bit ir, input int n, input logic [BSR_W-1:0] din,
		output logic [BSR_W-1:0] dout);
		logic q;
		dout = '0;
		tick(1'b1, ~tdi, q);
		if (ir) tick(1'b1, ~tdi, q);
		tick(1'b0, ~tdi, q);
		tick(1'b0, ~tdi, q);
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1, din[i], q);
			dout[i] = q;
		end
		tick(1'b1, ~din[n-1], q);
		tick(1'b0, din[n-1], q);
	endtask : scan
endmodule : scan_host

// ### bench/test_jtag_data_regs.sv
// Self-checking bench for the test port data registers and boundary chain.
`timescale 1ns/1ps
module test_jtag_data_regs;
	import scan_pkg::*;
	localparam logic [3:0]  VER   = 4'h3;     // Arbitrary value.
	localparam logic [15:0] PART  = 16'h1234; // Arbitrary value.
	localparam logic [10:0] MAKR  = 11'h155;  // Arbitrary value.
	localparam int          LIMIT = 40000;
	logic               clk, rst_n, tck, tms, tdi, tdo, tdo_oe;
	logic [N_OUT-1:0]   func_out, pin_out;
	logic [N_IN-1:0]    pin_in;
	logic [1:0]         sa0, sa1;
	logic [SLAVE_W-1:0] slave_addr;
	logic [FW_W-1:0]    fw_version;
	logic [MEM_W-1:0]   mem_addr, mem_rdata, mem_wr_addr, mem_wr_data, a, d;
	logic               mem_wr_valid, mem_wr_ready, soft_restart_instr, save_pulse;
	logic [BSR_W-1:0]   dout, ev;
	logic [31:0]        seed = 32'h2733;
	logic [15:0]        exp_q[$];
	int                 bad_count, comparisons, cycles, n_rst, n_save;

	jtag_data_regs #(.VERSION(VER), .PART_ID(PART), .MAKER(MAKR)) dut_u (
		.clk(clk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
		.func_out(func_out), .pin_out(pin_out), .pin_in(pin_in), .slave_addr_pin_0(sa0),
		.slave_addr_pin_1(sa1), .slave_addr(slave_addr), .fw_version(fw_version),
		.mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_wr_valid(mem_wr_valid),
		.mem_wr_ready(mem_wr_ready), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
		.soft_restart_instr(soft_restart_instr), .save_pulse(save_pulse)
	);
	scan_host host_u (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

	// Memory model: a fixed scramble of the address so each byte differs.
	assign mem_rdata = mem_addr ^ 8'h5a;

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic check(input string what, input logic [BSR_W-1:0] e, input logic [BSR_W-1:0] g);
		comparisons++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", what, e, g);
		end
	endtask : check

	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : final_report

	task automatic ir(input logic [IR_W-1:0] op);
		host_u.scan(1'b1, IR_W, BSR_W'(op), dout);
		check("ir capture", BSR_W'(IR_CAPTURE), dout);
	endtask : ir

	task automatic dr(input int n, input logic [BSR_W-1:0] din);
		host_u.scan(1'b0, n, din, dout);
		check("tdo enable idle", '0, BSR_W'(tdo_oe));
	endtask : dr

	// Output watcher: pulses are counted and each taken word is matched to the oldest note.
	always @(posedge clk) begin
		cycles++;
		if (soft_restart_instr === 1'b1) n_rst++;
		if (save_pulse === 1'b1) n_save++;
		if (mem_wr_valid === 1'b1 && mem_wr_ready === 1'b1)
			check("write word", exp_q.size() ? exp_q.pop_front() : 'x, {mem_wr_addr, mem_wr_data});
		if (cycles == LIMIT) begin
			bad_count++;
			final_report();
		end
	end

	// Main sequence; inputs change on the falling clock edge.
	initial begin
		rst_n = 1'b0;
		func_out = '0;
		pin_in = '0;
		sa0 = ADDR_HIZ;
		sa1 = ADDR_LOW;
		slave_addr = '0;
		fw_version = '0;
		mem_wr_ready = 1'b0;
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		host_u.reset_tap();
		// Identification is current after reset and again after a mode-select reset.
		for (int k = 0; k < 2; k++) begin
			dr(ID_W, '0);
			check("idcode", BSR_W'({VER, PART, MAKR, 1'b1}), dout);
			host_u.reset_tap();
		end
		seed = lfsr(seed);
		slave_addr = seed[6:0];
		fw_version = seed[15:8];
		ir(OP_USER);
		dr(ID_W, '0);
		check("usercode", BSR_W'({17'h0, slave_addr, fw_version}), dout);
		ir(OP_BYPASS);
		dr(1, '1);
		check("bypass", '0, dout);
		// Three writes against a stalled receiver fill the buffer and its pending stage.
		for (int k = 0; k < 5; k++) begin
			if (k == 3) mem_wr_ready = 1'b1;
			seed = lfsr(seed);
			a = seed[7:0];
			d = seed[15:8];
			ir(OP_LDADDR);
			dr(MEM_W, BSR_W'(a));
			check("mem_addr", BSR_W'(a), BSR_W'(mem_addr));
			exp_q.push_back({a, d});
			ir(OP_MEMWR);
			dr(MEM_W, BSR_W'(d));
			ir(OP_MEMRD);
			dr(MEM_W, '0);
			check("read byte", BSR_W'(a ^ 8'h5a), dout);
			if (k == 2) check("stalled valid", 1'b1, mem_wr_valid);
		end
		repeat (4) @(negedge clk);
		check("writes left", '0, BSR_W'(exp_q.size()));
		ir(OP_SOFT_RESTART);
		check("restart count", 1, n_rst);
		ir(OP_SAVE);
		check("pulse counts", BSR_W'(64'h1_0000_0001), BSR_W'({n_rst, n_save}));
		// Sample every address pin state while the core keeps driving its pins.
		ir(OP_SAMPLE);
		for (int k = 0; k < 3; k++) begin
			seed = lfsr(seed);
			func_out = seed[8:0];
			pin_in = seed[12:9];
			sa0 = k[1:0];
			sa1 = 2'h2 - k[1:0];
			ev = '0;
			ev[CELL_OUT0 +: N_OUT] = func_out;
			ev[CELL_SCL:CELL_GPIO2I] = {pin_in[3], sa1, sa0, pin_in[2:0]};
			dr(BSR_W, '0);
			check("sample chain", ev, dout);
			check("sample pins", BSR_W'(func_out), BSR_W'(pin_out));
		end
		seed = lfsr(seed);
		ev = '0;
		ev[CELL_OUT0 +: N_OUT] = seed[8:0];
		ir(OP_EXTEST);
		dr(BSR_W, ev);
		check("extest pins", BSR_W'(ev[CELL_OUT0 +: N_OUT]), BSR_W'(pin_out));
		ir(OP_BYPASS);
		check("released pins", BSR_W'(func_out), BSR_W'(pin_out));
		final_report();
	end
endmodule : test_jtag_data_regs
